// [verilog/bfp_protect.v]
// boot flash self-programming protection and read-while-write arbitration
// Summary of operation
// - stores from application section are ignored
// - boot-section stores may target any address
// - boot section start comes from fuses
// - cpu runs during read-while-write section programming
// - cpu halted while programming no-read-while-write section
// - busy flag set while rww section blocked
// - busy stays after programming until software clears
// - boot section always inside no-read-while-write section
// - lock bits only program; chip erase restores
// - general memory lock never gates self-programming
// - application lock field encodings gate stores/loads
// - boot lock field encodings gate stores/loads
// - app lock suppresses irqs, vectors in boot
// - boot lock suppresses irqs, vectors in app
// - one is unprogrammed, zero is programmed
// - two independent lock fields
`include "bfp_defines.vh"
`default_nettype none

module bfp_protect #(
  parameter PROG_CYCLES = `BFP_PROG_TIME_US * `BFP_CLK_MHZ  // page erase/write length
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // cpu program-memory request
  input  wire        req_valid,
  input  wire        req_store,
  input  wire [1:0]  req_op,
  input  wire [15:0] req_pc,
  input  wire [15:0] req_addr,
  output reg         resp_valid,
  output reg         resp_grant,
  // cpu side status
  input  wire        ivec_in_boot,
  output wire        cpu_halt,
  output wire        rww_read_block,
  output wire        irq_suppress,
  output wire        irq,
  // fuse pins and external programming port
  input  wire [1:0]  boot_size_fuses,
  input  wire        ext_lock_wr,
  input  wire [3:0]  ext_lock_data,
  input  wire        chip_erase
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [1:0]  fuse_s1_q;        // fuse synchroniser, first stage
  reg  [1:0]  fuse_q;           // fuse synchroniser, second stage
  reg  [3:0]  lock_q;           // both lock fields
  reg         rww_busy_q;       // read-while-write section busy flag
  reg         prog_q;           // page erase or write in progress
  reg         prog_no_read_while_write_section_q;      // current program targets no_read_while_write_section area
  reg  [31:0] prog_cnt_q;       // remaining program cycles
  reg  [2:0]  irq_stat_q;       // sticky event bits
  reg  [2:0]  irq_mask_q;       // interrupt enables
  reg         aw_hold_q;        // write address captured
  reg  [4:0]  aw_addr_q;        // captured write address
  reg         w_hold_q;         // write data captured
  reg  [31:0] w_data_q;         // captured write data
  reg  [3:0]  w_strb_q;         // captured strobes
  reg  [15:0] boot_start;       // first word of boot section
  wire        pc_boot;          // instruction runs from boot section
  wire        tgt_boot;         // target lies in boot section
  wire        tgt_no_read_while_write_section;         // target lies in no_read_while_write_section area
  wire        app_no_st;        // application section store lock
  wire        app_no_ld;        // application section load lock
  wire        boot_no_st;       // boot section store lock
  wire        boot_no_ld;       // boot section load lock
  reg         allow;            // combinational verdict
  wire        is_prog_op;       // erase or write
  wire        wr_go;            // register write fires
  wire        rd_go;            // register read accepted
  wire        req_fire;         // request accepted this cycle
  wire        prog_done;        // last program cycle
  reg  [2:0]  ev;               // events this cycle
  wire [31:0] wr_val;           // write data, byte-lane masked

  ////////////////////////////////////////////////////////////////////////////
  // fuse pins cross two flip-flops before use
  always @(posedge aclk) begin
    if (!aresetn) begin
      fuse_s1_q <= 2'h3;
      fuse_q    <= 2'h3;
    end else begin
      fuse_s1_q <= boot_size_fuses;
      fuse_q    <= fuse_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // section decode
  // boot start from fuses; every choice sits at or above no_read_while_write_section start
  always @* begin
    case (fuse_q)
      2'h3:    boot_start = `BFP_BOOT_11;
      2'h2:    boot_start = `BFP_BOOT_10;
      2'h1:    boot_start = `BFP_BOOT_01;
      default: boot_start = `BFP_BOOT_00;
    endcase
  end

  // instruction and target sections compared before locks apply
  assign pc_boot  = (req_pc >= boot_start);
  assign tgt_boot = (req_addr >= boot_start);
  assign tgt_no_read_while_write_section = (req_addr >= `BFP_NO_READ_WHILE_WRITE_SECTION_START);

  // lock decode: a zero bit is programmed
  assign app_no_st  = ~lock_q[`BFP_LOCK_APP_LO];     // modes 10 and 00
  assign app_no_ld  = ~lock_q[`BFP_LOCK_APP_HI];     // modes 00 and 01
  assign boot_no_st = ~lock_q[`BFP_LOCK_BOOT_LO];
  assign boot_no_ld = ~lock_q[`BFP_LOCK_BOOT_HI];

  assign is_prog_op = (req_op == `BFP_OP_ERASE) || (req_op == `BFP_OP_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // access verdict; no general memory lock input exists, so none gates it
  always @* begin
    allow = 1'b1;
    if (req_store) begin
      if (!pc_boot) begin
        allow = 1'b0;
      end else if (tgt_boot) begin
        allow = ~boot_no_st;
      end else begin
        allow = ~app_no_st;
      end
      // a second erase or write cannot start while one runs
      if (prog_q && is_prog_op) begin
        allow = 1'b0;
      end
    end else begin
      // loads across sections obey the target's load lock
      if (pc_boot && !tgt_boot && app_no_ld) begin
        allow = 1'b0;
      end
      if (!pc_boot && tgt_boot && boot_no_ld) begin
        allow = 1'b0;
      end
      // rww data cannot be read while the section is blocked
      if (!tgt_no_read_while_write_section && rww_busy_q) begin
        allow = 1'b0;
      end
    end
  end

  // requests wait while the cpu is halted
  assign req_fire = req_valid && !cpu_halt;

  ////////////////////////////////////////////////////////////////////////////
  // request answer: one cycle after acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid <= 1'b0;
      resp_grant <= 1'b0;
    end else begin
      resp_valid <= req_fire;
      resp_grant <= req_fire && allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming timer and busy flag
  assign prog_done = prog_q && (prog_cnt_q == 32'h1);

  always @(posedge aclk) begin
    if (!aresetn) begin
      prog_q      <= 1'b0;
      prog_no_read_while_write_section_q <= 1'b0;
      prog_cnt_q  <= 32'h0;
      rww_busy_q  <= 1'b0;
    end else begin
      if (req_fire && allow && req_store && is_prog_op) begin
        // start: rww target keeps cpu running, no_read_while_write_section target halts it
        prog_q      <= 1'b1;
        prog_no_read_while_write_section_q <= tgt_no_read_while_write_section;
        prog_cnt_q  <= PROG_CYCLES;
        if (!tgt_no_read_while_write_section) begin
          rww_busy_q <= 1'b1;
        end
      end else if (prog_q) begin
        prog_cnt_q <= prog_cnt_q - 32'h1;
        if (prog_done) begin
          prog_q      <= 1'b0;
          prog_no_read_while_write_section_q <= 1'b0;
        end
      end
      // busy outlives programming until re-enable or a page fill;
      // a programming start in the same cycle wins over a clear
      if (rww_busy_q && !prog_q && !(req_fire && allow && req_store && is_prog_op)) begin
        if (wr_go && (aw_addr_q == `BFP_REG_CTRL) && wr_val[`BFP_CTRL_RWW_REEN]) begin
          rww_busy_q <= 1'b0;
        end
        if (req_fire && allow && req_store && (req_op == `BFP_OP_FILL)) begin
          rww_busy_q <= 1'b0;
        end
      end
    end
  end

  // halt covers the whole no_read_while_write_section operation; rww blocked while busy
  assign cpu_halt       = prog_q && prog_no_read_while_write_section_q;
  assign rww_read_block = rww_busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt suppression from locked vectors
  assign irq_suppress = (ivec_in_boot && !pc_boot && app_no_ld)
                      || (!ivec_in_boot && pc_boot && boot_no_ld);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign wr_go         = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_val        = { {8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}} } & w_data_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= 5'h00;
      w_hold_q     <= 1'b0;
      w_data_q     <= 32'h0;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      // capture address
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      // capture data
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      // respond once both are in
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr_q)
          `BFP_REG_CTRL, `BFP_REG_STATUS, `BFP_REG_LOCK,
          `BFP_REG_IRQ_STAT, `BFP_REG_IRQ_MASK: s_axi_bresp <= 2'h0;
          default:                              s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock bits: writes only program (clear) bits; chip erase restores ones
  always @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= `BFP_LOCK_RESET;
    end else if (chip_erase) begin
      lock_q <= `BFP_LOCK_RESET;
    end else begin
      // all four bits are and-ed at once; a field written with ones is untouched
      if (wr_go && (aw_addr_q == `BFP_REG_LOCK) && ext_lock_wr) begin
        lock_q <= lock_q & (wr_val[3:0] | ~{4{w_strb_q[0]}}) & ext_lock_data;
      end else if (wr_go && (aw_addr_q == `BFP_REG_LOCK)) begin
        lock_q <= lock_q & (wr_val[3:0] | ~{4{w_strb_q[0]}});
      end else if (ext_lock_wr) begin
        lock_q <= lock_q & ext_lock_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over a write-one clear
  always @* begin
    ev = 3'h0;
    ev[`BFP_IRQ_DONE]    = prog_done;
    ev[`BFP_IRQ_ST_DENY] = req_fire && req_store && !allow;
    ev[`BFP_IRQ_LD_DENY] = req_fire && !req_store && !allow;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      if (wr_go && (aw_addr_q == `BFP_REG_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~wr_val[2:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (wr_go && (aw_addr_q == `BFP_REG_IRQ_MASK) && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[2:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path: one answer at a time
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0;
      case (s_axi_araddr)
        `BFP_REG_CTRL: begin
          s_axi_rdata <= 32'h0;                      // action bit reads zero
        end
        `BFP_REG_STATUS: begin
          s_axi_rdata[`BFP_STAT_RWW_BUSY] <= rww_busy_q;
          s_axi_rdata[`BFP_STAT_PROG]     <= prog_q;
          s_axi_rdata[`BFP_STAT_HALT]     <= cpu_halt;
          s_axi_rdata[`BFP_STAT_FUSE_HI:`BFP_STAT_FUSE_LO] <= fuse_q;
        end
        `BFP_REG_LOCK: begin
          s_axi_rdata[3:0] <= lock_q;
        end
        `BFP_REG_IRQ_STAT: begin
          s_axi_rdata[2:0] <= irq_stat_q;
        end
        `BFP_REG_IRQ_MASK: begin
          s_axi_rdata[2:0] <= irq_mask_q;
        end
        default: begin
          s_axi_rresp <= 2'h2;                       // unmapped: slave error
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [verilog/bfp_defines.vh]
// constants for the boot flash protection block
`ifndef BFP_DEFINES_VH
`define BFP_DEFINES_VH

// register byte offsets on the axi4-lite bus
`define BFP_REG_CTRL      5'h00
`define BFP_REG_STATUS    5'h04
`define BFP_REG_LOCK      5'h08
`define BFP_REG_IRQ_STAT  5'h0c
`define BFP_REG_IRQ_MASK  5'h10

// control register fields
`define BFP_CTRL_RWW_REEN 0

// status register fields
`define BFP_STAT_RWW_BUSY 0
`define BFP_STAT_PROG     1
`define BFP_STAT_HALT     2
`define BFP_STAT_FUSE_LO  4
`define BFP_STAT_FUSE_HI  5

// lock register fields: one means unprogrammed
`define BFP_LOCK_APP_LO   0
`define BFP_LOCK_APP_HI   1
`define BFP_LOCK_BOOT_LO  2
`define BFP_LOCK_BOOT_HI  3
`define BFP_LOCK_RESET    4'hf

// interrupt status bits
`define BFP_IRQ_DONE      0
`define BFP_IRQ_ST_DENY   1
`define BFP_IRQ_LD_DENY   2
`define BFP_IRQ_W         3

// store operation codes
`define BFP_OP_FILL       2'h0
`define BFP_OP_ERASE      2'h1
`define BFP_OP_WRITE      2'h2

// flash map in words; the fixed no-read-while-write area is the top
`define BFP_AW            16
`define BFP_NO_READ_WHILE_WRITE_SECTION_START    16'hf000
`define BFP_BOOT_11       16'hfe00
`define BFP_BOOT_10       16'hfc00
`define BFP_BOOT_01       16'hf800
`define BFP_BOOT_00       16'hf000

// page program time
`define BFP_PROG_TIME_US  4000
`define BFP_CLK_MHZ       40

`endif

// [testbench/bfp_protect_monitor.sv]
// concurrent checks on the ports of the flash protection block
`default_nettype none
module bfp_protect_monitor #(
  parameter int PROG_CYCLES = 8
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus write data valid
  input wire logic        s_axi_wvalid,
  // cpu request and answer
  input wire logic        req_valid,
  input wire logic        req_store,
  input wire logic [1:0]  req_op,
  input wire logic [15:0] req_pc,
  input wire logic [15:0] req_addr,
  input wire logic        resp_valid,
  input wire logic        resp_grant,
  // status levels
  input wire logic        cpu_halt,
  input wire logic        rww_read_block
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] run_q;  // length of the current halt run
  ////////////////////////////////////////////////////////////////
  // count consecutive halted cycles
  always @(posedge aclk) begin
    if (!aresetn) run_q <= 32'h0;
    else run_q <= cpu_halt ? run_q + 32'h1 : 32'h0;
  end
  ////////////////////////////////////////////////////////////////
  a_resp_next: assert property (req_valid && !cpu_halt |=> resp_valid)
    else $error("taken request got no answer");
  a_no_take_halt: assert property (!(req_valid && !cpu_halt) |=> !resp_valid)
    else $error("answer without a taken request");
  a_app_store_deny: assert property (
    req_valid && !cpu_halt && req_store && req_pc < 16'hf000 |=> !resp_grant)
    else $error("store from application section granted");
  a_rww_busy_set: assert property (
    resp_valid && resp_grant && $past(req_store && (req_op == 2'h1 || req_op == 2'h2) && req_addr < 16'hf000)
    |-> rww_read_block)
    else $error("rww programming without busy");
  a_rww_cpu_runs: assert property (
    resp_valid && resp_grant && $past(req_store && (req_op == 2'h1 || req_op == 2'h2) && req_addr < 16'hf000)
    |-> !cpu_halt)
    else $error("cpu halted for rww programming");
  a_no_read_while_write_section_halt: assert property (
    resp_valid && resp_grant && $past(req_store && (req_op == 2'h1 || req_op == 2'h2) && req_addr >= 16'hf000)
    |-> cpu_halt)
    else $error("cpu not halted for no_read_while_write_section programming");
  a_halt_full_len: assert property ($fell(cpu_halt) |-> run_q >= PROG_CYCLES)
    else $error("halt shorter than programming");
  a_busy_held: assert property (
    $fell(rww_read_block) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
    || $past(req_valid) || $past(req_valid, 2))
    else $error("busy dropped without software action");
endmodule
bind bfp_protect bfp_protect_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid), .req_valid(req_valid),
  .req_store(req_store), .req_op(req_op), .req_pc(req_pc), .req_addr(req_addr),
  .resp_valid(resp_valid), .resp_grant(resp_grant), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block));
`default_nettype wire

// [testbench/bfp_cpu_model.sv]
// cpu core model issuing program-memory loads and stores
`default_nettype none
module bfp_cpu_model (
  // clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // command from the bench
  input wire logic         go,
  input wire logic         st,
  input wire logic [1:0]   op,
  input wire logic [15:0]  pc,
  input wire logic [15:0]  ad,
  // block status and answer
  input wire logic         cpu_halt,
  input wire logic         rww_read_block,
  input wire logic         resp_valid,
  input wire logic         resp_grant,
  // request to the block
  output var logic         req_valid,
  output var logic         req_store,
  output var logic [1:0]   req_op,
  output var logic [15:0]  req_pc,
  output var logic [15:0]  req_addr,
  // answer back to the bench
  output var logic         got,
  output var logic         gnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_q;  // command latched, not yet raised
  ////////////////////////////////////////////////////////////////
  // latch a command, raise it, hold it until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      {req_valid, req_store, req_op, req_pc, req_addr, got, gnt, pend_q} <= '0;
    end else begin
      got <= resp_valid;
      gnt <= resp_grant;
      if (go) begin
        {req_store, req_op, req_pc, req_addr} <= {st, op, pc, ad};
        pend_q <= 1'b1;
      end else if (pend_q && !(!req_store && req_addr < 16'hf000 && rww_read_block)) begin
        // no rww reads while that section is blocked
        req_valid <= 1'b1;
        pend_q <= 1'b0;
      end
      if (req_valid && !cpu_halt) begin
        req_valid <= 1'b0;
        req_addr <= ~req_addr;  // idle address must not look valid
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/bfp_protect_tb.sv]
// self-checking bench for the boot flash protection block
`include "bfp_defines.vh"
`default_nettype none
module bfp_protect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ivec, ext_wr, erase;
  logic        go, st, got, gnt, awready, wready, bvalid, arready, rvalid, halt, blk, supp, irq;
  logic        req_valid, req_store, resp_valid, resp_grant;
  logic [1:0]  op, bresp, rresp, rsp, fuses, req_op;
  logic [3:0]  ext_data;
  logic [4:0]  awaddr, araddr;
  logic [15:0] pc, ad, bs, req_pc, req_addr;
  logic [31:0] wdata, rdata, rdat;
  int          miscompares, checks;
  bfp_protect #(.PROG_CYCLES(16)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req_valid(req_valid), .req_store(req_store),
    .req_op(req_op), .req_pc(req_pc), .req_addr(req_addr), .resp_valid(resp_valid), .resp_grant(resp_grant),
    .ivec_in_boot(ivec), .cpu_halt(halt), .rww_read_block(blk), .irq_suppress(supp), .irq(irq),
    .boot_size_fuses(fuses), .ext_lock_wr(ext_wr), .ext_lock_data(ext_data), .chip_erase(erase));
  bfp_cpu_model u_cpu (
    .aclk(aclk), .aresetn(aresetn), .go(go), .st(st), .op(op), .pc(pc), .ad(ad), .cpu_halt(halt),
    .rww_read_block(blk), .resp_valid(resp_valid), .resp_grant(resp_grant), .req_valid(req_valid),
    .req_store(req_store), .req_op(req_op), .req_pc(req_pc), .req_addr(req_addr), .got(got), .gnt(gnt));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ka, kw;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(negedge aclk);
      ka = awvalid && awready;
      kw = wvalid && wready;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end while (!(ka || !awvalid) || !(kw || !wvalid));
    do @(negedge aclk); while (!bvalid);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    @(negedge aclk);
  endtask
  // bus read into rdat and rsp
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    {rdat, rsp} = {rdata, rresp};
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // one cpu request through the model, grant compared with e
  task automatic cq(input logic s, input logic [1:0] o, input logic [15:0] p, input logic [15:0] a, input logic e);
    @(posedge aclk);
    {st, op, pc, ad, go} <= {s, o, p, a, 1'b1};
    @(posedge aclk);
    go <= 1'b0;
    do @(negedge aclk); while (!got);
    chk("grant", {31'h0, e}, {31'h0, gnt});
  endtask
  // chip erase pulse
  task automatic wipe();
    @(posedge aclk);
    erase <= 1'b1;
    @(posedge aclk);
    erase <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ivec, ext_wr, erase, go, st} = '0;
    {awaddr, araddr, wdata, op, pc, ad, ext_data} = '0;
    fuses = 2'h3;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`BFP_REG_LOCK);
    chk("lock reset", 32'hf, rdat);
    for (int f = 0; f < 4; f++) begin
      fuses <= f[1:0];
      bs = (f == 3) ? 16'hfe00 : (f == 2) ? 16'hfc00 : (f == 1) ? 16'hf800 : 16'hf000;
      repeat (3) @(posedge aclk);
      rd(`BFP_REG_STATUS);
      chk("fuses", f, rdat[5:4]);
      cq(1'b1, `BFP_OP_FILL, bs, 16'h0000, 1'b1);
      cq(1'b1, `BFP_OP_FILL, bs - 16'h1, 16'h0000, 1'b0);
    end
    chk("irq masked", 0, irq);
    wr(`BFP_REG_IRQ_MASK, 32'h2);
    chk("bresp ok", 32'h0, rsp);
    chk("irq raised", 1, irq);
    wr(`BFP_REG_IRQ_STAT, 32'h2);
    chk("irq cleared", 0, irq);
    cq(1'b1, `BFP_OP_ERASE, 16'hff00, 16'h1000, 1'b1);
    // a second erase while the first still runs is refused
    cq(1'b1, `BFP_OP_ERASE, 16'hff00, 16'h2000, 1'b0);
    cq(1'b0, `BFP_OP_FILL, 16'hff00, 16'hf100, 1'b1);
    chk("halt rww", 0, halt);
    rd(`BFP_REG_STATUS);
    chk("busy", 1, rdat[0]);
    repeat (12) @(posedge aclk);
    rd(`BFP_REG_STATUS);
    chk("busy held", 1, rdat[1:0]);
    rd(`BFP_REG_IRQ_STAT);
    chk("irq status", 32'h3, rdat);
    wr(`BFP_REG_CTRL, 32'h1);
    rd(`BFP_REG_STATUS);
    chk("busy cleared", 0, rdat[0]);
    cq(1'b0, `BFP_OP_FILL, 16'hff00, 16'h1000, 1'b1);
    cq(1'b1, `BFP_OP_WRITE, 16'hff00, 16'hf800, 1'b1);
    chk("halt no_read_while_write_section", 1, halt);
    cq(1'b0, `BFP_OP_FILL, 16'h0100, 16'h0200, 1'b1);
    for (int e = 0; e < 4; e++) begin
      wipe();
      ivec <= 1'b1;
      wr(`BFP_REG_LOCK, 32'hc | e);
      rd(`BFP_REG_LOCK);
      chk("lock", 32'hc | e, rdat);
      cq(1'b1, `BFP_OP_FILL, 16'hff00, 16'h0100, e[0]);
      cq(1'b0, `BFP_OP_FILL, 16'hff00, 16'h0100, e[1]);
      cq(1'b0, `BFP_OP_FILL, 16'h0100, 16'h0200, 1'b1);
      chk("suppress app", !e[1], supp);
      wipe();
      ivec <= 1'b0;
      wr(`BFP_REG_LOCK, 32'h3 | (e << 2));
      cq(1'b1, `BFP_OP_FILL, 16'hff00, 16'hfe10, e[0]);
      cq(1'b0, `BFP_OP_FILL, 16'h0100, 16'hfe10, e[1]);
      cq(1'b0, `BFP_OP_FILL, 16'hfe00, 16'hfe10, 1'b1);
      chk("suppress boot", !e[1], supp);
    end
    @(posedge aclk);
    {ext_data, ext_wr} <= {4'h6, 1'b1};
    @(posedge aclk);
    ext_wr <= 1'b0;
    wr(`BFP_REG_LOCK, 32'hf);
    rd(`BFP_REG_LOCK);
    chk("lock kept", 32'h6, rdat);
    wipe();
    rd(`BFP_REG_LOCK);
    chk("lock erased", 32'hf, rdat);
    rd(5'h14);
    chk("unmapped", 32'h2, rsp);
    wr(5'h14, 32'h0);
    chk("unmapped wr", 32'h2, rsp);
    print_verdict();
  end
endmodule
`default_nettype wire
